// ==== hdl/event_status.sv ====
// event latching, masking, clear-on-read status and interrupt of the framer link controller
//
// Function
// - reading any of the four status registers clears all its bits
// - with masked-visible set, masked events latch but raise neither interrupt nor pending
// - message end set when short message or final part plus status byte stored
// - frame start event two bytes after a valid frame start is detected
// - sync missing when no eight consecutive ones within 32 bits in message mode
// - rx multiframe begin set at each received multiframe start
// - signaling change only in sync when update differs; host reads in time
// - checksum error set when the six-bit check of last multiframe fails
// - density violation: over 15 zeros or under 23 ones in 192 bits
// - status-change mode reports density, blue and no-signal on every change
// - pool full set when 32 bytes of an unfinished frame are stored
// - signaling empty at tx multiframe start; every 12 frames in F72
// - overflow set as soon as receive data is lost
// - all sent set when last bit left and transmit queue empty
// - underrun aborts frame, holds transmitter until tx status read
// - tx multiframe begin set at each generated multiframe start
// - line change on rising line-open or any change of line-short
// - pool ready set when the transmit queue becomes able to take 32 bytes
// - alignment back on falling loss, or when simulation ends in sync
// - F12/F72: multiframe back on falling loss, lost on rising loss
// - alarm simulation forces loss, multiframe, blue, no-signal, remote events
// - remote alarm on rising status; cleared on fall or simulation end clear
// - global pending register shows which status registers hold unmasked events
`timescale 1ns/1ps
`include "evt_regs.svh"
module event_status
   import evt_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // register port
   input wire logic [7:0] addr,
   input wire logic [7:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [7:0] rd_data,
   output logic irq,
   // receive controller
   input wire logic rx_byte_wr,
   input wire logic rx_status_wr,
   input wire logic rx_frame_start_det,
   input wire logic rx_byte_lost,
   input wire logic [3:0] rx_frame_length_high,
   // receive bit stream
   input wire logic rx_bit,
   input wire logic rx_bit_en,
   input wire logic bom_active,
   output logic density_status,
   // framer
   input wire frame_fmt_e frame_format,
   input wire logic rx_mf_start,
   input wire logic rx_sig_update,
   input wire logic rx_sig_differs,
   input wire logic in_sync,
   input wire logic rx_crc_done,
   input wire logic rx_crc_fail,
   input wire logic frame_align_lost,
   input wire logic multiframe_loss,
   input wire logic blue_alarm,
   input wire logic no_signal_alarm,
   input wire logic remote_alarm_status,
   input wire logic alarm_sim,
   input wire logic [7:0] misc_events,
   // transmit controller
   input wire logic tx_frame_start,
   input wire logic tx_last_bit_out,
   input wire logic tx_fifo_empty,
   input wire logic tx_underrun_det,
   input wire logic tx_message_end_cmd,
   input wire logic tx_space_ok,
   input wire logic tx_line_open,
   input wire logic tx_line_short,
   output logic tx_hold,
   output logic tx_abort
);

   localparam state_s RST_STATE = '{
      msk_a: `RST_MASK, msk_b: `RST_MASK, msk_c: `RST_MASK, msk_d: `RST_MASK,
      default: '0
   };

   logic [1:0] rst_pipe;
   logic rst_sync_n;
   state_s q;
   state_s d;
   logic [7:0] set_a;
   logic [7:0] set_b;
   logic [7:0] set_c;
   logic [7:0] global_pending;
   logic rd_a;
   logic rd_b;
   logic rd_c;
   logic rd_d;
   logic sync_miss;
   logic [6:0] mf_len;

   // reset release through two flops, assertion stays asynchronous
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rst_pipe <= 2'h0;
      end else begin
         rst_pipe <= {rst_pipe[0], 1'b1};
      end
   end
   assign rst_sync_n = rst_pipe[1];

   // read strobes of the clear-on-read registers
   assign rd_a = rd_en && (addr == `OFS_RX_EVT_A);
   assign rd_b = rd_en && (addr == `OFS_TX_EVT);
   assign rd_c = rd_en && (addr == `OFS_ALARM_EVT);
   assign rd_d = rd_en && (addr == `OFS_MISC_EVT);

   assign global_pending = {4'h0, |(q.st_d & ~q.msk_d), |(q.st_c & ~q.msk_c),
                            |(q.st_b & ~q.msk_b), |(q.st_a & ~q.msk_a)};
   assign irq = |global_pending;
   assign rd_data = q.rdata;
   assign density_status = q.density_bad;
   assign tx_hold = q.tx_hold;
   assign tx_abort = q.tx_abort;

   // multiframe length by format
   always_comb begin
      case (frame_format)
         FMT_ESF: mf_len = 7'(`MF_LEN_ESF);
         FMT_F12: mf_len = 7'(`MF_LEN_F12);
         FMT_F72: mf_len = 7'(`MF_LEN_F72);
         default: mf_len = 7'(`MF_LEN_ESF);
      endcase
   end

   // next state
   always_comb begin
      d = q;
      set_a = 8'h00;
      set_b = 8'h00;
      set_c = 8'h00;
      sync_miss = 1'b0;
      d.tx_abort = 1'b0;

      // density check: zero run and sliding window
      if (rx_bit_en) begin
         d.win = {q.win[`DENS_WINDOW-2:0], rx_bit};
         d.ones = q.ones + 8'(rx_bit) - 8'(q.win[`DENS_WINDOW-1]);
         if (q.fill != 8'(`DENS_WINDOW)) begin
            d.fill = q.fill + 8'h01;
            d.ones = q.ones + 8'(rx_bit);
         end
         if (rx_bit) begin
            d.zero_run = 5'h00;
         end else if (q.zero_run <= 5'(`DENS_MAX_ZEROS)) begin
            d.zero_run = q.zero_run + 5'h01;
         end
      end
      d.density_bad = (d.zero_run > 5'(`DENS_MAX_ZEROS))
                      || ((d.fill == 8'(`DENS_WINDOW)) && (d.ones < 8'(`DENS_N)));

      // eight ones must show within each 32-bit span
      if (!bom_active) begin
         d.bom_run = 4'h0;
         d.bom_bits = 6'h00;
      end else if (rx_bit_en) begin
         d.bom_run = rx_bit ? q.bom_run + 4'h1 : 4'h0;
         d.bom_bits = q.bom_bits + 6'h01;
         if (d.bom_run == 4'(`SYNC_ONES)) begin
            d.bom_run = 4'h0;
            d.bom_bits = 6'h00;
         end else if (d.bom_bits == 6'(`SYNC_SPAN)) begin
            sync_miss = 1'b1;
            d.bom_bits = 6'h00;
         end
      end

      // message end once the trailing status byte is stored
      set_a[`A_MSG_END] = rx_status_wr;
      // pool full every 32 bytes of an unfinished frame
      if (rx_status_wr) begin
         d.rx_chunk = 6'h00;
      end else if (rx_byte_wr) begin
         d.rx_chunk = q.rx_chunk + 6'h01;
         if (q.rx_chunk == 6'(`POOL_BYTES - 1)) begin
            d.rx_chunk = 6'h00;
            set_a[`A_POOL_FULL] = 1'b1;
         end
      end
      // frame start delayed by two stored bytes
      if (rx_frame_start_det) begin
         d.rfs_arm = 1'b1;
         d.rfs_cnt = 2'h0;
      end else if (q.rfs_arm && rx_byte_wr) begin
         d.rfs_cnt = q.rfs_cnt + 2'h1;
         if (q.rfs_cnt == 2'(`FRAME_START_DELAY - 1)) begin
            d.rfs_arm = 1'b0;
            set_a[`A_FRAME_START] = 1'b1;
         end
      end
      set_a[`A_SYNC_MISSING] = sync_miss;
      set_a[`A_MF_BEGIN] = rx_mf_start;
      // signaling change only while in sync
      set_a[`A_SIG_CHANGED] = rx_sig_update && rx_sig_differs && in_sync;
      set_a[`A_CHECKSUM_ERR] = rx_crc_done && rx_crc_fail;
      // density event on rise, or any change in status-change mode
      d.pd_prev = q.density_bad;
      set_a[`A_DENSITY] = q.chg_mode ? (q.density_bad != q.pd_prev)
                                     : (q.density_bad && !q.pd_prev);

      // transmit multiframe and signaling refill timing
      if (tx_frame_start) begin
         d.tx_frame = (q.tx_frame + 7'h01 >= mf_len) ? 7'h00 : q.tx_frame + 7'h01;
         d.tx_sub = (q.tx_sub == 4'(`SIG_PERIOD_F72 - 1)) ? 4'h0 : q.tx_sub + 4'h1;
         set_b[`B_MF_BEGIN] = (q.tx_frame == 7'h00);
         set_b[`B_SIG_EMPTY] = (frame_format == FMT_F72) ? (q.tx_sub == 4'h0)
                                                         : (q.tx_frame == 7'h00);
      end
      // overflow as soon as data is lost
      set_b[`B_OVERFLOW] = rx_byte_lost;
      // all sent only with an empty queue
      set_b[`B_ALL_SENT] = tx_last_bit_out && tx_fifo_empty;
      // underrun without end command aborts and holds transmitter
      if (tx_underrun_det && !tx_message_end_cmd && !q.tx_hold) begin
         set_b[`B_UNDERRUN] = 1'b1;
         d.tx_abort = 1'b1;
      end
      // line open rising, line short any change
      d.open_prev = tx_line_open;
      d.short_prev = tx_line_short;
      set_b[`B_LINE_CHG] = (tx_line_open && !q.open_prev) || (tx_line_short != q.short_prev);
      // pool ready when space for a block appears
      d.space_prev = tx_space_ok;
      set_b[`B_POOL_READY] = tx_space_ok && !q.space_prev;

      // alarm edges
      d.lfa_prev = frame_align_lost;
      d.mfl_prev = multiframe_loss;
      d.blue_prev = blue_alarm;
      d.nosig_prev = no_signal_alarm;
      d.rem_prev = remote_alarm_status;
      d.sim_prev = alarm_sim;
      // alignment back on fall, or simulation end while synchronized
      set_c[`C_ALIGN_BACK] = (!frame_align_lost && q.lfa_prev)
                             || (!alarm_sim && q.sim_prev && !frame_align_lost);
      set_c[`C_ALIGN_LOST] = frame_align_lost && !q.lfa_prev;
      // multiframe edges only in F12 or F72
      if (frame_format != FMT_ESF) begin
         set_c[`C_MF_BACK] = !multiframe_loss && q.mfl_prev;
         set_c[`C_MF_LOST] = multiframe_loss && !q.mfl_prev;
      end
      // blue and no-signal follow status-change mode
      set_c[`C_BLUE] = q.chg_mode ? (blue_alarm != q.blue_prev) : (blue_alarm && !q.blue_prev);
      set_c[`C_NO_SIGNAL] = q.chg_mode ? (no_signal_alarm != q.nosig_prev)
                                       : (no_signal_alarm && !q.nosig_prev);
      // remote alarm rise, and cleared on fall or simulation end
      set_c[`C_REMOTE] = remote_alarm_status && !q.rem_prev;
      set_c[`C_REMOTE_CLR] = (!remote_alarm_status && q.rem_prev)
                             || (!alarm_sim && q.sim_prev && !remote_alarm_status);
      if (alarm_sim) begin
         set_c = set_c | 8'h7D;
      end

      // masked events latch only when masked-visible is on
      if (!q.show_masked) begin
         set_a = set_a & ~q.msk_a;
         set_b = set_b & ~q.msk_b;
         set_c = set_c & ~q.msk_c;
      end

      // clear on read; a set in the same cycle wins
      d.st_a = (rd_a ? 8'h00 : q.st_a) | set_a;
      d.st_b = (rd_b ? 8'h00 : q.st_b) | set_b;
      d.st_c = (rd_c ? 8'h00 : q.st_c) | set_c;
      d.st_d = (rd_d ? 8'h00 : q.st_d) | (misc_events & (q.show_masked ? 8'hFF : ~q.msk_d));

      // hold ends with a read of tx status; new underrun wins
      if (set_b[`B_UNDERRUN] || d.tx_abort) begin
         d.tx_hold = 1'b1;
      end else if (rd_b) begin
         d.tx_hold = 1'b0;
      end

      // register writes
      if (wr_en) begin
         case (addr)
            `OFS_CTRL: begin
               d.show_masked = wr_data[`CTRL_SHOW_MASKED];
               d.chg_mode = wr_data[`CTRL_CHG_MODE];
            end
            `OFS_MASK_A: d.msk_a = wr_data;
            `OFS_MASK_B: d.msk_b = wr_data;
            `OFS_MASK_C: d.msk_c = wr_data;
            `OFS_MASK_D: d.msk_d = wr_data;
            default: d.show_masked = q.show_masked;
         endcase
      end

      // read data, returned in the next cycle only
      d.rdata = 8'h00;
      if (rd_en) begin
         case (addr)
            `OFS_CTRL: d.rdata = {6'h00, q.chg_mode, q.show_masked};
            `OFS_MASK_A: d.rdata = q.msk_a;
            `OFS_MASK_B: d.rdata = q.msk_b;
            `OFS_MASK_C: d.rdata = q.msk_c;
            `OFS_MASK_D: d.rdata = q.msk_d;
            `OFS_RX_LEN_HIGH: d.rdata = {4'h0, rx_frame_length_high};
            `OFS_RX_EVT_A: d.rdata = q.st_a;
            `OFS_TX_EVT: d.rdata = q.st_b;
            `OFS_ALARM_EVT: d.rdata = q.st_c;
            `OFS_MISC_EVT: d.rdata = q.st_d;
            `OFS_GLOBAL: d.rdata = global_pending;
            default: d.rdata = 8'h00;
         endcase
      end
   end

   // state register
   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         q <= RST_STATE;
      end else begin
         q <= d;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_sync_n);

   a_read_clears_a: assert property (
      rd_a && set_a == 8'h00 |=> q.st_a == 8'h00) else $error("status a not cleared by read");
   a_masked_quiet: assert property (
      ((q.st_a & ~q.msk_a) == 8'h00) && ((q.st_b & ~q.msk_b) == 8'h00)
      && ((q.st_c & ~q.msk_c) == 8'h00) && ((q.st_d & ~q.msk_d) == 8'h00) |-> !irq)
      else $error("interrupt raised by masked bits");
   a_irq_pending: assert property (
      (q.st_c[`C_REMOTE] && !q.msk_c[`C_REMOTE]) |-> irq && global_pending[2])
      else $error("unmasked bit without interrupt");
   a_msg_end_set: assert property (
      rx_status_wr && !q.msk_a[`A_MSG_END] |=> q.st_a[`A_MSG_END])
      else $error("message end not latched");
   a_zero_run_flag: assert property (
      rx_bit_en && !rx_bit && q.zero_run == 5'h0F |=> q.density_bad)
      else $error("sixteen zeros not flagged");
   a_sync_span: assert property (
      bom_active && rx_bit_en && !rx_bit && q.bom_bits == 6'h1F |-> sync_miss)
      else $error("missing sync pattern not reported");
   a_hold_until_read: assert property (
      q.tx_hold && !rd_b |=> q.tx_hold) else $error("transmitter released without read");
   a_underrun_abort: assert property (
      tx_underrun_det && !tx_message_end_cmd && !q.tx_hold |=> tx_abort && tx_hold)
      else $error("underrun did not abort");
   a_line_open_edge: assert property (
      $rose(tx_line_open) && !q.msk_b[`B_LINE_CHG] |=> q.st_b[`B_LINE_CHG])
      else $error("line open edge lost");
   a_remote_rise: assert property (
      $rose(remote_alarm_status) && !q.msk_c[`C_REMOTE] |=> q.st_c[`C_REMOTE])
      else $error("remote alarm edge lost");
   a_rfs_delay: assert property (
      rx_frame_start_det ##1 (!rx_byte_wr && !rx_frame_start_det)
      ##1 (rx_byte_wr && !rx_frame_start_det) |-> !set_a[`A_FRAME_START])
      else $error("frame start raised after one byte");

   c_irq_rise: cover property ($rose(irq));
   c_underrun: cover property (tx_underrun_det && !tx_message_end_cmd);
   c_sim_end: cover property ($fell(alarm_sim));
   c_density: cover property ($rose(q.density_bad));

endmodule : event_status

// ==== hdl/evt_regs.svh ====
// register offsets, field positions, reset values and counts of the event status block
`ifndef EVT_REGS_SVH
`define EVT_REGS_SVH

// register offsets
`define OFS_CTRL 8'h12
`define OFS_MASK_A 8'h14
`define OFS_MASK_B 8'h15
`define OFS_MASK_C 8'h16
`define OFS_MASK_D 8'h17
`define OFS_RX_LEN_HIGH 8'h67
`define OFS_RX_EVT_A 8'h68
`define OFS_TX_EVT 8'h69
`define OFS_ALARM_EVT 8'h6A
`define OFS_MISC_EVT 8'h6B
`define OFS_GLOBAL 8'h6E

// control register fields
`define CTRL_SHOW_MASKED 0
`define CTRL_CHG_MODE 1

// rx_event_status_a fields
`define A_MSG_END 7
`define A_FRAME_START 6
`define A_SYNC_MISSING 5
`define A_MF_BEGIN 4
`define A_SIG_CHANGED 3
`define A_CHECKSUM_ERR 2
`define A_DENSITY 1
`define A_POOL_FULL 0

// tx_event_status fields, bit 0 reserved
`define B_SIG_EMPTY 7
`define B_OVERFLOW 6
`define B_ALL_SENT 5
`define B_UNDERRUN 4
`define B_MF_BEGIN 3
`define B_LINE_CHG 2
`define B_POOL_READY 1

// alarm_event_status fields
`define C_ALIGN_BACK 7
`define C_ALIGN_LOST 6
`define C_MF_BACK 5
`define C_MF_LOST 4
`define C_BLUE 3
`define C_NO_SIGNAL 2
`define C_REMOTE_CLR 1
`define C_REMOTE 0

// reset values
`define RST_STATUS 8'h00
`define RST_MASK 8'hFF

// counts
`define POOL_BYTES 32
`define FRAME_START_DELAY 2
`define SYNC_ONES 8
`define SYNC_SPAN 32
`define DENS_MAX_ZEROS 15
`define DENS_N 23
`define DENS_WINDOW (8 * (`DENS_N + 1))
`define MF_LEN_ESF 24
`define MF_LEN_F12 12
`define MF_LEN_F72 72
`define SIG_PERIOD_F72 12

`endif

// ==== hdl/evt_pkg.sv ====
// types of the event status block
package evt_pkg;
`include "evt_regs.svh"

   typedef enum logic [1:0] {
      FMT_ESF,
      FMT_F12,
      FMT_F72
   } frame_fmt_e;

   typedef struct packed {
      logic [7:0] st_a;
      logic [7:0] st_b;
      logic [7:0] st_c;
      logic [7:0] st_d;
      logic [7:0] msk_a;
      logic [7:0] msk_b;
      logic [7:0] msk_c;
      logic [7:0] msk_d;
      logic show_masked;
      logic chg_mode;
      logic [7:0] rdata;
      logic pd_prev;
      logic blue_prev;
      logic nosig_prev;
      logic lfa_prev;
      logic mfl_prev;
      logic rem_prev;
      logic open_prev;
      logic short_prev;
      logic sim_prev;
      logic space_prev;
      logic [4:0] zero_run;
      logic [`DENS_WINDOW-1:0] win;
      logic [7:0] ones;
      logic [7:0] fill;
      logic density_bad;
      logic [3:0] bom_run;
      logic [5:0] bom_bits;
      logic [5:0] rx_chunk;
      logic rfs_arm;
      logic [1:0] rfs_cnt;
      logic [6:0] tx_frame;
      logic [3:0] tx_sub;
      logic tx_hold;
      logic tx_abort;
   } state_s;

endpackage : evt_pkg

// ==== bench/host_model.sv ====
// host processor model driving the register port of the event status block
`timescale 1ns/1ps
module host_model #(
   parameter int GAP = 3
) (
   // clock
   input wire logic clock,
   // register port
   output logic [7:0] addr,
   output logic [7:0] wr_data,
   output logic wr_en,
   output logic rd_en,
   input wire logic [7:0] rd_data
);
   // idle bus from time zero
   initial begin
      addr = 8'h00;
      wr_data = 8'h00;
      wr_en = 1'b0;
      rd_en = 1'b0;
   end

   // one-cycle write strobe, the slave never stalls
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge clock);
      wr_en <= 1'b0;
   endtask : wr

   // status read after GAP idle cycles
   // data stand only in the cycle after the strobe, so they are taken mid-cycle
   task rd(input logic [7:0] a, output logic [7:0] d);
      repeat (GAP) @(posedge clock);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clock);
      rd_en <= 1'b0;
      @(negedge clock);
      d = rd_data;
   endtask : rd
endmodule : host_model

// ==== bench/event_status_tb_top.sv ====
// self-checking bench of the event status block
`timescale 1ns/1ps
`include "evt_regs.svh"
module event_status_tb_top
   import evt_pkg::*;
();
   localparam int P_BYTE = 0, P_STAT = 1, P_FST = 2, P_LOST = 3, P_MF = 4, P_SIG = 5;
   localparam int P_CRC = 6, P_TXF = 7, P_LAST = 8, P_UND = 9;
   localparam int L_ALIGN = 0, L_MFL = 1, L_BLUE = 2, L_NOSIG = 3, L_REM = 4;
   localparam int L_SIM = 5, L_OPEN = 6, L_SHORT = 7, L_SPACE = 8;
   logic clock, rd_en, wr_en, irq, density_status, tx_hold, tx_abort;
   logic rst_n = 1'b0;
   logic [7:0] addr, wr_data, rd_data, outs, got;
   logic [7:0] misc_events = 8'h00;
   logic [9:0] pl = '0;
   logic [8:0] lv = '0;
   logic rx_byte_wr, rx_status_wr, rx_frame_start_det, rx_byte_lost, rx_mf_start;
   logic rx_sig_update, rx_crc_done, tx_frame_start, tx_last_bit_out, tx_underrun_det;
   logic frame_align_lost, multiframe_loss, blue_alarm, no_signal_alarm, remote_alarm_status;
   logic alarm_sim, tx_line_open, tx_line_short, tx_space_ok;
   logic rx_bit = 1'b0, rx_bit_en = 1'b0, bom_active = 1'b0, rx_sig_differs = 1'b1;
   logic in_sync = 1'b1, rx_crc_fail = 1'b1, tx_fifo_empty = 1'b0, tx_message_end_cmd = 1'b0;
   logic [3:0] rx_frame_length_high = 4'hA;
   frame_fmt_e frame_format = FMT_ESF;
   int num_errors = 0;
   int n_tests = 0;

   // pulses and levels live in two vectors so one task can drive any of them
   assign {tx_underrun_det, tx_last_bit_out, tx_frame_start, rx_crc_done, rx_sig_update,
      rx_mf_start, rx_byte_lost, rx_frame_start_det, rx_status_wr, rx_byte_wr} = pl;
   assign {tx_space_ok, tx_line_short, tx_line_open, alarm_sim, remote_alarm_status,
      no_signal_alarm, blue_alarm, multiframe_loss, frame_align_lost} = lv;
   assign outs = {4'h0, density_status, tx_abort, tx_hold, irq};

   event_status dut (
      .clock, .rst_n, .addr, .wr_data, .wr_en, .rd_en, .rd_data, .irq,
      .rx_byte_wr, .rx_status_wr, .rx_frame_start_det, .rx_byte_lost, .rx_frame_length_high,
      .rx_bit, .rx_bit_en, .bom_active, .density_status, .frame_format, .rx_mf_start,
      .rx_sig_update, .rx_sig_differs, .in_sync, .rx_crc_done, .rx_crc_fail,
      .frame_align_lost, .multiframe_loss, .blue_alarm, .no_signal_alarm,
      .remote_alarm_status, .alarm_sim, .misc_events, .tx_frame_start, .tx_last_bit_out,
      .tx_fifo_empty, .tx_underrun_det, .tx_message_end_cmd, .tx_space_ok, .tx_line_open,
      .tx_line_short, .tx_hold, .tx_abort
   );
   host_model host (.clock, .addr, .wr_data, .wr_en, .rd_en, .rd_data);

   // bench clock, 8 ns period
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   // compare and count
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   // read a register and compare
   task rc(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      host.rd(a, d);
      chk(d, e);
   endtask : rc

   // look at outputs at a falling edge, after the launching edge has settled
   task ochk(input int n, input logic [7:0] m, input logic [7:0] e);
      repeat (n) @(negedge clock);
      chk(outs & m, e);
   endtask : ochk

   // one-cycle pulses with a quiet cycle between them
   task pulse(input int k, input int n);
      repeat (n) begin
         @(posedge clock);
         pl[k] <= 1'b1;
         @(posedge clock);
         pl[k] <= 1'b0;
      end
   endtask : pulse

   // move one level, then read the status register it feeds
   task setc(input int k, input logic v, input logic [7:0] a, input logic [7:0] e);
      @(posedge clock);
      lv[k] <= v;
      rc(a, e);
   endtask : setc

   // bit stream: per 0 all zeros, else a one at the end of every per bits
   task bits(input int n, input int per);
      for (int i = 0; i < n; i++) begin
         @(posedge clock);
         rx_bit_en <= 1'b1;
         rx_bit <= (per != 0) && ((i % per) == per - 1);
      end
      @(posedge clock);
      rx_bit_en <= 1'b0;
   endtask : bits

   task tdone(input string s);
      $display("test %s done", s);
   endtask : tdone

   // the single place where the run ends
   task stop_test();
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : stop_test

   // a hang costs a mismatch; the tests need some 1800 cycles
   initial begin
      repeat (20000) @(posedge clock);
      num_errors++;
      stop_test();
   end

   // test sequence
   initial begin
      repeat (8) @(posedge clock);
      rst_n <= 1'b1;
      repeat (3) @(posedge clock);
      for (int k = 0; k < 4; k++) rc(8'(`OFS_RX_EVT_A + k), `RST_STATUS);
      rc(`OFS_MASK_A, `RST_MASK);
      rc(`OFS_GLOBAL, 8'h00);
      ochk(1, 8'h07, 8'h00);
      rc(8'h00, 8'h00);
      host.wr(`OFS_RX_EVT_A, 8'hFF);
      rc(`OFS_RX_EVT_A, 8'h00);
      rc(`OFS_RX_LEN_HIGH, 8'h0A);
      for (int k = 0; k < 4; k++) host.wr(8'(`OFS_MASK_A + k), 8'h00);
      tdone("reset");
      pulse(P_FST, 1);
      pulse(P_BYTE, 1);
      rc(`OFS_RX_EVT_A, 8'h00);
      pulse(P_BYTE, 1);
      rc(`OFS_RX_EVT_A, 8'h40);
      pulse(P_BYTE, 29);
      rc(`OFS_RX_EVT_A, 8'h00);
      pulse(P_BYTE, 1);
      pulse(P_STAT, 1);
      ochk(2, 8'h01, 8'h01);
      rc(`OFS_GLOBAL, 8'h01);
      rc(`OFS_RX_EVT_A, 8'h81);
      rc(`OFS_RX_EVT_A, 8'h00);
      ochk(1, 8'h01, 8'h00);
      pulse(P_LOST, 1);
      rc(`OFS_TX_EVT, 8'h40);
      pulse(P_MF, 1);
      pulse(P_CRC, 1);
      pulse(P_SIG, 1);
      rc(`OFS_RX_EVT_A, 8'h1C);
      @(posedge clock);
      in_sync <= 1'b0;
      rx_crc_fail <= 1'b0;
      pulse(P_CRC, 1);
      pulse(P_SIG, 1);
      rc(`OFS_RX_EVT_A, 8'h00);
      @(posedge clock) in_sync <= 1'b1;
      tdone("receive events");
      bits(15, 0);
      rc(`OFS_RX_EVT_A, 8'h00);
      bits(1, 0);
      ochk(2, 8'h08, 8'h08);
      rc(`OFS_RX_EVT_A, 8'h02);
      host.wr(`OFS_CTRL, 8'h02);
      bits(200, 1);
      rc(`OFS_RX_EVT_A, 8'h02);
      bits(400, 9);
      ochk(2, 8'h08, 8'h08);
      rc(`OFS_RX_EVT_A, 8'h02);
      bits(400, 8);
      ochk(2, 8'h08, 8'h00);
      rc(`OFS_RX_EVT_A, 8'h02);
      bits(40, 2);
      rc(`OFS_RX_EVT_A, 8'h00);
      @(posedge clock);
      bom_active <= 1'b1;
      bits(8, 1);
      host.rd(`OFS_RX_EVT_A, got);
      bits(30, 2);
      rc(`OFS_RX_EVT_A, 8'h00);
      bits(4, 2);
      rc(`OFS_RX_EVT_A, 8'h20);
      @(posedge clock) bom_active <= 1'b0;
      tdone("bit stream");
      pulse(P_TXF, 1);
      rc(`OFS_TX_EVT, 8'h88);
      pulse(P_TXF, 23);
      rc(`OFS_TX_EVT, 8'h00);
      pulse(P_TXF, 1);
      rc(`OFS_TX_EVT, 8'h88);
      @(posedge clock) frame_format <= FMT_F72;
      pulse(P_TXF, 12);
      rc(`OFS_TX_EVT, 8'h80);
      pulse(P_TXF, 60);
      rc(`OFS_TX_EVT, 8'h88);
      @(posedge clock) frame_format <= FMT_F12;
      pulse(P_TXF, 12);
      rc(`OFS_TX_EVT, 8'h88);
      pulse(P_LAST, 1);
      rc(`OFS_TX_EVT, 8'h00);
      @(posedge clock) tx_fifo_empty <= 1'b1;
      pulse(P_LAST, 1);
      rc(`OFS_TX_EVT, 8'h20);
      setc(L_OPEN, 1'b1, `OFS_TX_EVT, 8'h04);
      setc(L_OPEN, 1'b0, `OFS_TX_EVT, 8'h00);
      setc(L_SHORT, 1'b1, `OFS_TX_EVT, 8'h04);
      setc(L_SHORT, 1'b0, `OFS_TX_EVT, 8'h04);
      setc(L_SPACE, 1'b1, `OFS_TX_EVT, 8'h02);
      @(posedge clock) tx_message_end_cmd <= 1'b1;
      pulse(P_UND, 1);
      ochk(1, 8'h06, 8'h00);
      rc(`OFS_TX_EVT, 8'h00);
      @(posedge clock) tx_message_end_cmd <= 1'b0;
      pulse(P_UND, 1);
      ochk(1, 8'h06, 8'h06);
      ochk(1, 8'h06, 8'h02);
      pulse(P_UND, 1);
      ochk(1, 8'h06, 8'h02);
      rc(`OFS_TX_EVT, 8'h10);
      ochk(1, 8'h06, 8'h00);
      tdone("transmit events");
      setc(L_ALIGN, 1'b1, `OFS_ALARM_EVT, 8'h40);
      setc(L_ALIGN, 1'b0, `OFS_ALARM_EVT, 8'h80);
      setc(L_MFL, 1'b1, `OFS_ALARM_EVT, 8'h10);
      setc(L_MFL, 1'b0, `OFS_ALARM_EVT, 8'h20);
      setc(L_BLUE, 1'b1, `OFS_ALARM_EVT, 8'h08);
      setc(L_BLUE, 1'b0, `OFS_ALARM_EVT, 8'h08);
      setc(L_NOSIG, 1'b1, `OFS_ALARM_EVT, 8'h04);
      setc(L_NOSIG, 1'b0, `OFS_ALARM_EVT, 8'h04);
      setc(L_REM, 1'b1, `OFS_ALARM_EVT, 8'h01);
      setc(L_REM, 1'b0, `OFS_ALARM_EVT, 8'h02);
      setc(L_SIM, 1'b1, `OFS_ALARM_EVT, 8'h7D);
      setc(L_SIM, 1'b0, `OFS_ALARM_EVT, 8'hFF);
      rc(`OFS_ALARM_EVT, 8'h00);
      tdone("alarms");
      host.wr(`OFS_CTRL, 8'h00);
      host.wr(`OFS_MASK_D, 8'h0F);
      @(posedge clock);
      misc_events <= 8'hFF;
      @(posedge clock);
      misc_events <= 8'h00;
      ochk(2, 8'h01, 8'h01);
      rc(`OFS_GLOBAL, 8'h08);
      rc(`OFS_MISC_EVT, 8'hF0);
      ochk(1, 8'h01, 8'h00);
      host.wr(`OFS_CTRL, 8'h01);
      host.wr(`OFS_MASK_D, 8'hFF);
      @(posedge clock);
      misc_events <= 8'hFF;
      @(posedge clock);
      misc_events <= 8'h00;
      ochk(2, 8'h01, 8'h00);
      rc(`OFS_GLOBAL, 8'h00);
      rc(`OFS_MISC_EVT, 8'hFF);
      tdone("masking");
      stop_test();
   end
endmodule : event_status_tb_top
